/* File: rtl/dma_arbiter.sv */
// Priority arbiter for the transfer channels
`timescale 1ns/10ps
`include "dma_defs.svh"
module dma_arbiter (
   input wire logic [`DMA_NUM_CH-1:0] elig_i,
   input wire dma_pkg::prio_vec_t prio_i,
   input wire logic [`DMA_CH_W-1:0] cur_i,
   output logic grant_valid_o,
   output logic [`DMA_CH_W-1:0] grant_idx_o,
   output logic preempt_o
);
   import dma_pkg::*;

   // Highest priority wins, lower channel number wins a tie
   always_comb begin
      logic found;
      logic [`DMA_CH_W-1:0] best;
      logic higher;
      found = 1'b0;
      best = '0;
      higher = 1'b0;
      for (int i = `DMA_NUM_CH - 1; i >= 0; i--) begin
         if (elig_i[i] && (!found || prio_i[i] >= prio_i[best])) begin // see [RQ15]
            found = 1'b1;
            best = `DMA_CH_W'(i);
         end
         if (elig_i[i] && prio_i[i] > prio_i[cur_i]) begin // see [RQ16]
            higher = 1'b1;
         end
      end
      grant_valid_o = found;
      grant_idx_o = best;
      preempt_o = higher;
   end
endmodule // dma_arbiter

/* File: rtl/dma_controller.sv */
// Eight-channel transfer controller with Wishbone registers
`timescale 1ns/10ps
`include "dma_defs.svh"
// Notes on behaviour
// [RQ1] Eight independent channels, each optionally paced by a peripheral request.
// [RQ2] Source and destination pointers are full 32-bit words.
// [RQ3] A valid pair selector routes receive to channel x, transmit to y; acks back.
// [RQ4] Equal selector values: the less significant selector field gets the routing.
// [RQ5] Setting the on bit starts a channel; hardware clears it when finished.
// [RQ6] Trigger mode 0 starts at once; mode 1 waits for the routed request.
// [RQ7] Items of 8, 16 or 32 bits are copied source to destination.
// [RQ8] Sixteen-bit index cleared at start, stepped per item, compared with length.
// [RQ9] Address is start plus index shifted by one or two for wider items.
// [RQ10] Cleared increment enable holds that side's address constant.
// [RQ11] Continue while the start condition holds; stop at index equal length.
// [RQ12] Circular restarts from zero, but software-started channels always stop.
// [RQ13] Interrupt when match value equals index, after the item, before stepping.
// [RQ14] Length 0 with match 0 gives one item and one interrupt.
// [RQ15] Highest 3-bit priority is granted; ties go to the lower channel.
// [RQ16] Yield lets a higher requester preempt a software channel; ignored otherwise.
// [RQ17] Fill mode locks the bus, reads once and writes repeatedly.
// [RQ18] Software uses fill mode only for memory initialisation.
// [RQ19] Freeze-set bits suspend channels, freeze-clear bits resume them.
// [RQ20] A running software memory copy finishes before its freeze takes hold.
// [RQ21] Software keeps peripheral clock divider zero for transmit to serial ports.
// [RQ22] No check of channel programming; any setting is executed as given.
// [RQ23] Each item is one bus read then one bus write at the item width; in fill mode only the first item reads.
module dma_controller (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`DMA_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [`DMA_NUM_PAIR-1:0] periph_rx_req_i,
   input wire logic [`DMA_NUM_PAIR-1:0] periph_tx_req_i,
   output logic [`DMA_NUM_PAIR-1:0] periph_rx_ack_o,
   output logic [`DMA_NUM_PAIR-1:0] periph_tx_ack_o,
   output logic mem_req_o,
   output dma_pkg::mem_cmd_s mem_cmd_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i,
   output logic mem_lock_o,
   output logic [`DMA_NUM_CH-1:0] irq_o
);
   import dma_pkg::*;

   function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] calc_addr(input logic [31:0] base, input logic [15:0] idx,
                                             input logic [1:0] width, input logic inc);
      logic [31:0] off;
      off = {16'h0000, idx};
      unique case (width)
         `DMA_W8: off = off;
         `DMA_W16: off = off << 1; // see [RQ9]
         default: off = off << 2;
      endcase
      return inc ? base + off : base; // see [RQ10]
   endfunction

   function automatic logic [31:0] item_mask(input logic [31:0] d, input logic [1:0] width);
      logic [31:0] r;
      unique case (width)
         `DMA_W8: r = {24'h000000, d[7:0]}; // see [RQ7]
         `DMA_W16: r = {16'h0000, d[15:0]};
         default: r = d;
      endcase
      return r;
   endfunction

   // Register state
   logic [31:0] src_q [`DMA_NUM_CH];
   logic [31:0] dst_q [`DMA_NUM_CH];
   logic [`DMA_IDX_W-1:0] len_q [`DMA_NUM_CH];
   logic [`DMA_IDX_W-1:0] match_q [`DMA_NUM_CH];
   logic [`DMA_IDX_W-1:0] idx_q [`DMA_NUM_CH];
   chan_ctrl_s ctrl_q [`DMA_NUM_CH]; // see [RQ1]
   logic [`DMA_NUM_FIELD*`DMA_SEL_W-1:0] route_q;
   logic [`DMA_NUM_CH-1:0] frozen_q;
   logic wb_ack_q;
   logic [31:0] wb_dat_q;
   state_e state_q, state_d;
   logic [`DMA_CH_W-1:0] cur_q;
   mem_cmd_s cmd_q, cmd_d;
   logic [`DMA_NUM_CH-1:0] ack_q;
   logic [`DMA_NUM_CH-1:0] irq_q;

   // Bus decode
   wire logic wb_req = wb_cyc_i & wb_stb_i;
   wire logic wr_stb = wb_req & wb_we_i & wb_ack_q;
   wire logic in_ch = wb_adr_i[`DMA_ADR_REGION] == `DMA_REGION_CH;
   wire logic in_glb = wb_adr_i[`DMA_ADR_REGION] == `DMA_REGION_GLB;
   wire logic [`DMA_CH_W-1:0] wch = wb_adr_i[`DMA_ADR_CH];
   wire logic [2:0] wrd = wb_adr_i[`DMA_ADR_WORD];
   wire logic wr_ch = wr_stb & in_ch;
   wire logic wr_glb = wr_stb & in_glb;
   wire logic wr_ctrl = wr_ch & (wrd == `DMA_REG_CTRL);
   wire logic [31:0] ctrl_new = merge_sel({20'h00000, ctrl_q[wch]}, wb_dat_i, wb_sel_i);
   wire logic [31:0] frz_set = merge_sel(32'h0, wb_dat_i, wb_sel_i);
   wire logic [31:0] len_new = merge_sel({16'h0000, len_q[wch]}, wb_dat_i, wb_sel_i);
   wire logic [31:0] match_new = merge_sel({16'h0000, match_q[wch]}, wb_dat_i, wb_sel_i);
   wire logic [31:0] route_new = merge_sel({16'h0000, route_q}, wb_dat_i, wb_sel_i);

   // Request routing
   logic [`DMA_SEL_W-1:0] sel_f [`DMA_NUM_FIELD];
   logic [`DMA_NUM_CH-1:0] chan_dreq;
   always_comb begin
      logic ok;
      chan_dreq = '0;
      periph_rx_ack_o = '0;
      periph_tx_ack_o = '0;
      ok = 1'b0;
      for (int k = 0; k < `DMA_NUM_FIELD; k++) begin
         sel_f[k] = route_q[k*`DMA_SEL_W +: `DMA_SEL_W];
         ok = sel_f[k] < `DMA_SEL_LIMIT;
         for (int j = 0; j < k; j++) begin
            if (sel_f[j] == sel_f[k]) begin
               ok = 1'b0; // see [RQ4]
            end
         end
         if (ok) begin
            chan_dreq[2*k] = periph_rx_req_i[sel_f[k]]; // see [RQ3]
            chan_dreq[2*k+1] = periph_tx_req_i[sel_f[k]];
            periph_rx_ack_o[sel_f[k]] = ack_q[2*k];
            periph_tx_ack_o[sel_f[k]] = ack_q[2*k+1];
         end
      end
   end

   // Arbitration
   logic [`DMA_NUM_CH-1:0] elig;
   prio_vec_t prio_vec;
   logic grant_valid;
   logic [`DMA_CH_W-1:0] grant_idx;
   logic preempt;
   always_comb begin
      for (int i = 0; i < `DMA_NUM_CH; i++) begin
         prio_vec[i] = ctrl_q[i].prio;
         elig[i] = ctrl_q[i].on & ~frozen_q[i] & (~ctrl_q[i].trig | chan_dreq[i]); // see [RQ6]
      end
   end

   dma_arbiter u_arb (
      .elig_i(elig),
      .prio_i(prio_vec),
      .cur_i(cur_q),
      .grant_valid_o(grant_valid),
      .grant_idx_o(grant_idx),
      .preempt_o(preempt)
   );

   // Engine decode
   wire chan_ctrl_s cc = ctrl_q[cur_q];
   wire chan_ctrl_s gc = ctrl_q[grant_idx];
   wire logic [`DMA_IDX_W-1:0] cidx = idx_q[cur_q];
   wire logic last_item = cidx == len_q[cur_q]; // see [RQ11] [RQ14]
   wire logic wrap = last_item & cc.circ & cc.trig; // see [RQ12]
   wire logic finish = (last_item & ~wrap) | ~cc.on;
   wire logic [`DMA_IDX_W-1:0] nidx = last_item ? `DMA_IDX_RST : cidx + `DMA_IDX_STEP;
   wire logic item_done = (state_q == ST_WRITE) & mem_ack_i;
   wire logic irq_hit = item_done & (match_q[cur_q] == cidx);

   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      unique case (state_q)
         ST_IDLE: begin
            if (grant_valid) begin
               state_d = ST_READ;
               cmd_d = '{we: 1'b0, width: gc.width, wdata: 32'h0,
                         addr: calc_addr(src_q[grant_idx], idx_q[grant_idx], gc.width, gc.sinc)};
            end
         end
         ST_READ: begin
            if (mem_ack_i) begin
               state_d = ST_WRITE; // see [RQ23]
               cmd_d.we = 1'b1;
               cmd_d.wdata = item_mask(mem_rdata_i, cc.width);
               cmd_d.addr = calc_addr(dst_q[cur_q], cidx, cc.width, cc.dinc);
            end
         end
         ST_WRITE: begin
            if (mem_ack_i) begin
               if (finish) begin
                  state_d = ST_DONE; // see [RQ11]
               end else if (cc.fill) begin
                  state_d = ST_WRITE; // see [RQ17]
                  cmd_d.addr = calc_addr(dst_q[cur_q], nidx, cc.width, cc.dinc);
               end else if (~cc.trig & ~(cc.yield & preempt)) begin
                  state_d = ST_READ; // see [RQ16] [RQ20]
                  cmd_d.we = 1'b0;
                  cmd_d.addr = calc_addr(src_q[cur_q], nidx, cc.width, cc.sinc);
               end else begin
                  state_d = ST_DONE;
               end
            end
         end
         ST_DONE: state_d = ST_IDLE;
      endcase
   end

   assign mem_req_o = (state_q == ST_READ) | (state_q == ST_WRITE);
   assign mem_cmd_o = cmd_q;
   assign mem_lock_o = mem_req_o & cc.fill; // see [RQ17]
   assign irq_o = irq_q;
   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cur_q <= '0;
         cmd_q <= '0;
         ack_q <= '0;
         irq_q <= '0;
      end else begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         if (state_q == ST_IDLE && grant_valid) begin
            cur_q <= grant_idx;
         end
         ack_q <= '0;
         irq_q <= '0;
         ack_q[cur_q] <= item_done & cc.trig; // see [RQ3]
         irq_q[cur_q] <= irq_hit; // see [RQ13]
      end
   end

   logic [31:0] rd_data;

   // Bus slave: answer one cycle after the request, write at the ack edge
   always_comb begin
      logic [31:0] rd;
      rd = 32'h0;
      if (in_ch) begin
         unique case (wrd)
            `DMA_REG_SRC: rd = src_q[wch];
            `DMA_REG_DST: rd = dst_q[wch];
            `DMA_REG_LEN: rd = {16'h0000, len_q[wch]};
            `DMA_REG_MATCH: rd = {16'h0000, match_q[wch]};
            `DMA_REG_CTRL: rd = {20'h00000, ctrl_q[wch]};
            `DMA_REG_IDX: rd = {16'h0000, idx_q[wch]};
            default: rd = 32'h0;
         endcase
      end else if (in_glb) begin
         unique case (wrd)
            `DMA_REG_ROUTE: rd = {16'h0000, route_q};
            `DMA_REG_STATUS: begin
               rd[`DMA_NUM_CH-1:0] = {ctrl_q[7].on, ctrl_q[6].on, ctrl_q[5].on, ctrl_q[4].on,
                                      ctrl_q[3].on, ctrl_q[2].on, ctrl_q[1].on, ctrl_q[0].on};
               rd[2*`DMA_NUM_CH-1:`DMA_NUM_CH] = frozen_q;
               rd[2*`DMA_NUM_CH] = mem_req_o;
               rd[2*`DMA_NUM_CH+`DMA_CH_W:2*`DMA_NUM_CH+1] = cur_q;
            end
            default: rd = 32'h0;
         endcase
      end
      rd_data = rd;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h0;
      end else begin
         wb_ack_q <= wb_req & ~wb_ack_q;
         wb_dat_q <= rd_data;
      end
   end

   // Pointer, length and match registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `DMA_NUM_CH; i++) begin
            src_q[i] <= `DMA_PTR_RST;
            dst_q[i] <= `DMA_PTR_RST;
            len_q[i] <= `DMA_IDX_RST;
            match_q[i] <= `DMA_IDX_RST;
         end
      end else if (wr_ch) begin
         unique case (wrd)
            `DMA_REG_SRC: src_q[wch] <= merge_sel(src_q[wch], wb_dat_i, wb_sel_i); // see [RQ2]
            `DMA_REG_DST: dst_q[wch] <= merge_sel(dst_q[wch], wb_dat_i, wb_sel_i);
            `DMA_REG_LEN: len_q[wch] <= len_new[`DMA_IDX_W-1:0];
            `DMA_REG_MATCH: match_q[wch] <= match_new[`DMA_IDX_W-1:0];
            default: ;
         endcase
      end
   end

   // Control, index, routing and freeze; a software write wins over the engine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `DMA_NUM_CH; i++) begin
            ctrl_q[i] <= chan_ctrl_s'(`DMA_CTRL_RST);
            idx_q[i] <= `DMA_IDX_RST;
         end
         route_q <= `DMA_ROUTE_RST;
         frozen_q <= '0;
      end else begin
         if (item_done) begin
            idx_q[cur_q] <= nidx; // see [RQ8] [RQ12]
            if (finish) begin
               ctrl_q[cur_q].on <= 1'b0; // see [RQ5] [RQ11]
            end
         end
         if (wr_ctrl) begin
            ctrl_q[wch] <= chan_ctrl_s'(ctrl_new[`DMA_CTRL_W-1:0]); // see [RQ22]
            if (ctrl_new[0] & ~ctrl_q[wch].on) begin
               idx_q[wch] <= `DMA_IDX_RST; // see [RQ8]
            end
         end
         if (wr_glb && wrd == `DMA_REG_ROUTE) begin
            route_q <= route_new[`DMA_NUM_FIELD*`DMA_SEL_W-1:0];
         end
         if (wr_glb && wrd == `DMA_REG_FRZ_SET) begin
            frozen_q <= frozen_q | frz_set[`DMA_NUM_CH-1:0]; // see [RQ19]
         end
         if (wr_glb && wrd == `DMA_REG_FRZ_CLR) begin
            frozen_q <= frozen_q & ~frz_set[`DMA_NUM_CH-1:0]; // see [RQ19]
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   route_map_a: assert property ((sel_f[0] < `DMA_SEL_LIMIT) |-> // see [RQ3]
      (chan_dreq[1:0] == {periph_tx_req_i[sel_f[0]], periph_rx_req_i[sel_f[0]]}))
      else $error("route to first channel pair wrong");
   route_prio_a: assert property ((sel_f[1] == sel_f[0]) |-> (chan_dreq[3:2] == 2'b00)) // see [RQ4]
      else $error("duplicate selector took routing");
   trig_gate_a: assert property ((state_q == ST_IDLE && grant_valid && gc.trig) // see [RQ6]
      |=> (state_q == ST_READ && $past(chan_dreq[grant_idx])))
      else $error("request-mode channel started without request");
   freeze_gate_a: assert property ((state_q == ST_IDLE && grant_valid) |-> // see [RQ19]
      !frozen_q[grant_idx])
      else $error("frozen channel granted");
   rd_wr_a: assert property ((state_q == ST_READ && mem_ack_i) |=> // see [RQ23]
      (state_q == ST_WRITE && mem_cmd_o.we && mem_req_o))
      else $error("read not followed by write");
   addr_form_a: assert property ((state_q == ST_READ && !$past(wr_ch)) |-> // see [RQ9]
      (mem_cmd_o.addr == calc_addr(src_q[cur_q], cidx, cc.width, cc.sinc)))
      else $error("source address not start plus index");
   idx_step_a: assert property ((item_done && !finish && !wr_ctrl) |=> // see [RQ8]
      (idx_q[cur_q] == $past(nidx)))
      else $error("index did not step");
   on_clear_a: assert property ((item_done && last_item && !wrap && !wr_ctrl) |=> // see [RQ5]
      (!ctrl_q[$past(cur_q)].on ##1 state_q == ST_IDLE))
      else $error("finished channel still on");
   irq_match_a: assert property (irq_hit |=> // see [RQ13]
      irq_o[$past(cur_q)] ##1 !irq_o[$past(cur_q, 2)])
      else $error("match interrupt missing or long");
   fill_lock_a: assert property ((item_done && cc.fill && !finish) |=> // see [RQ17]
      (state_q == ST_WRITE && mem_lock_o && cur_q == $past(cur_q)))
      else $error("fill channel lost the bus");

   single_item_c: cover property (state_q == ST_IDLE ##1 state_q == ST_READ
      ##[1:20] (item_done && last_item && irq_hit));
   circular_c: cover property (item_done && wrap);
   preempt_c: cover property (item_done && !cc.trig && cc.yield && preempt && !finish);
   fill_c: cover property (item_done && cc.fill && !finish);
endmodule // dma_controller

/* File: rtl/dma_defs.svh */
// Constants of the eight-channel transfer controller
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

`define DMA_NUM_CH 8
`define DMA_CH_W 3
`define DMA_NUM_PAIR 10
`define DMA_SEL_LIMIT 4'hA
`define DMA_NUM_FIELD 4
`define DMA_SEL_W 4
`define DMA_IDX_W 16
`define CHANNEL_PRIORITY_W 3
`define DMA_CTRL_W 12
`define DMA_ADR_W 10

`define DMA_ADR_REGION 9:8
`define DMA_ADR_CH 7:5
`define DMA_ADR_WORD 4:2
`define DMA_REGION_CH 2'h0
`define DMA_REGION_GLB 2'h1

`define DMA_REG_SRC 3'h0
`define DMA_REG_DST 3'h1
`define DMA_REG_LEN 3'h2
`define DMA_REG_MATCH 3'h3
`define DMA_REG_CTRL 3'h4
`define DMA_REG_IDX 3'h5
`define DMA_REG_ROUTE 3'h0
`define DMA_REG_FRZ_SET 3'h1
`define DMA_REG_FRZ_CLR 3'h2
`define DMA_REG_STATUS 3'h3

`define DMA_W8 2'h0
`define DMA_W16 2'h1
`define DMA_W32 2'h2

`define DMA_CTRL_RST 12'h000
`define DMA_ROUTE_RST 16'hFFFF
`define DMA_PTR_RST 32'h0000_0000
`define DMA_IDX_RST 16'h0000
`define DMA_IDX_STEP 16'h0001

`endif

/* File: rtl/dma_pkg.sv */
// Types shared by the transfer controller files
package dma_pkg;
`include "dma_defs.svh"

   typedef enum {ST_IDLE, ST_READ, ST_WRITE, ST_DONE} state_e;

   typedef struct packed {
      logic fill;
      logic yield;
      logic [`CHANNEL_PRIORITY_W-1:0] prio;
      logic trig;
      logic circ;
      logic dinc;
      logic sinc;
      logic [1:0] width;
      logic on;
   } chan_ctrl_s;

   typedef struct packed {
      logic we;
      logic [1:0] width;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_cmd_s;

   typedef logic [`DMA_NUM_CH-1:0][`CHANNEL_PRIORITY_W-1:0] prio_vec_t;
endpackage

/* File: test/mem_model.sv */
// Memory slave model answering the controller's bus requests
`timescale 1ns/10ps
module mem_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic mem_req_i,
   input wire dma_pkg::mem_cmd_s mem_cmd_i,
   output logic mem_ack_o,
   output logic [31:0] mem_rdata_o
);
   import dma_pkg::*;
   logic [1:0] wait_q;
   initial begin
      mem_ack_o = 1'h0;
      mem_rdata_o = 32'h0;
      wait_q = 2'h0;
   end
   // One ack per request after zero to three idle cycles
   always @(posedge clk_i) begin
      mem_ack_o <= 1'h0;
      // Idle bus shows no stale data
      mem_rdata_o <= ~mem_rdata_o;
      if (rst_i) begin
         wait_q <= 2'h0;
      end else if (mem_req_i && !mem_ack_o) begin
         if (wait_q == 2'h0) begin
            mem_ack_o <= 1'h1;
            mem_rdata_o <= {mem_cmd_i.addr[15:0] ^ 16'h5A5A, mem_cmd_i.addr[31:16]};
            wait_q <= 2'($urandom_range(3));
         end else begin
            wait_q <= wait_q - 2'h1;
         end
      end
   end
endmodule // mem_model

/* File: test/tb_top.sv */
// Self-checking bench for the transfer controller
`timescale 1ns/10ps
module tb_top;
   import dma_pkg::*;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [9:0] wb_adr_i = '0, rx_req = '0, tx_req = '0, rx_ack, tx_ack;
   logic [3:0] wb_sel_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, mem_rdata_i, r;
   logic wb_ack_o, mem_req_o, mem_ack_i, mem_lock_o, lock_exp = 0;
   logic [7:0] irq_o;
   mem_cmd_s mem_cmd_o;
   chan_ctrl_s c;
   logic [63:0] exp_q[$];
   int err_count = 0, n_compared = 0, rd_count = 0, irq_count = 0, r0, len;
   initial forever #2.5 clk_i = ~clk_i;
   dma_controller u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .periph_rx_req_i(rx_req), .periph_tx_req_i(tx_req), .periph_rx_ack_o(rx_ack),
      .periph_tx_ack_o(tx_ack), .mem_req_o(mem_req_o), .mem_cmd_o(mem_cmd_o),
      .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .mem_lock_o(mem_lock_o),
      .irq_o(irq_o));
   mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
      .mem_cmd_i(mem_cmd_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
   function automatic logic [31:0] msk(input logic [1:0] w, input logic [31:0] d);
      return w == 2'h0 ? d & 32'hFF : (w == 2'h1 ? d & 32'hFFFF : d);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Memory writes in order, bus lock and interrupt pulses
   always @(posedge clk_i) begin
      irq_count += $countones(irq_o);
      if (!rst_i && mem_req_o) chk({31'h0, mem_lock_o}, {31'h0, lock_exp});
      if (!rst_i && mem_req_o && mem_ack_i && !mem_cmd_o.we) rd_count++;
      if (!rst_i && mem_req_o && mem_ack_i && mem_cmd_o.we) begin
         if (exp_q.size() == 0) chk(mem_cmd_o.addr, 32'hDEAD);
         else begin
            chk(mem_cmd_o.addr, exp_q[0][63:32]);
            chk(mem_cmd_o.wdata, exp_q[0][31:0]);
            void'(exp_q.pop_front());
         end
      end
   end
   task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      n = 0;
      do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'h1 && n < 40);
      r = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      if (n >= 40) begin err_count++; conclude(); end
   endtask
   task automatic wait_off(input int ch);
      int n;
      n = 0;
      do begin wb(1'h0, 10'h10C, 32'h0); n++; end while (r[ch] !== 1'h0 && n < 100);
      if (n >= 100) begin err_count++; conclude(); end
   endtask
   task automatic prog(input int ch, input logic [31:0] sp, dp, input int l, m);
      logic [9:0] b;
      b = 10'(ch * 32);
      wb(1'h1, b, sp);
      wb(1'h1, b + 10'h4, dp);
      wb(1'h1, b + 10'h8, 32'(l));
      wb(1'h1, b + 10'hC, 32'(m));
      wb(1'h1, b + 10'h10, {20'h0, c});
   endtask
   task automatic plan(input logic [31:0] sp, dp, input int l);
      for (int i = 0; i <= l; i++)
         exp_q.push_back({dp + (c.dinc ? 32'(i) << c.width : 32'h0),
            msk(c.width, (c.sinc && !c.fill) ? {sp[15:0] + 16'(i << c.width) ^ 16'h5A5A,
            sp[31:16] + 16'(((sp & 32'hFFFF) + (32'(i) << c.width)) >> 16)}
            : {sp[15:0] ^ 16'h5A5A, sp[31:16]})});
   endtask
   task automatic run(input int ch, l, m);
      logic [31:0] sp, dp;
      int i0;
      sp = $urandom;
      dp = $urandom;
      r0 = rd_count;
      i0 = irq_count;
      plan(sp, dp, l);
      lock_exp = c.fill;
      prog(ch, sp, dp, l, m);
      wait_off(ch);
      repeat (3) @(posedge clk_i);
      chk(exp_q.size(), 0);
      chk(rd_count - r0, c.fill ? 1 : l + 1);
      chk(irq_count - i0, 32'(m <= l));
      c.on = 1'h0;
      wb(1'h0, 10'(ch * 32 + 16), 32'h0);
      chk(r, {20'h0, c});
      wb(1'h0, 10'(ch * 32 + 20), 32'h0);
      chk(r, 32'h0);
      lock_exp = 1'h0;
   endtask
   // Stand-in peripheral on the bus clock drops its request when acked
   task automatic pitem(input logic tx);
      int n;
      @(posedge clk_i);
      if (tx) tx_req[3] <= 1'h1;
      else rx_req[3] <= 1'h1;
      n = 0;
      do begin @(posedge clk_i); n++; end while ((tx ? tx_ack[3] : rx_ack[3]) !== 1'h1 && n < 60);
      tx_req[3] <= 1'h0;
      rx_req[3] <= 1'h0;
      if (n >= 60) begin err_count++; conclude(); end
   endtask
   initial begin
      void'($urandom(32'h1034B454));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      wb(1'h0, 10'h100, 32'h0);
      chk(r, 32'hFFFF);
      wb(1'h1, 10'h3FC, 32'hFFFFFFFF);
      wb(1'h0, 10'h3FC, 32'h0);
      chk(r, 32'h0);
      c = '0;
      c.on = 1'h1;
      run(7, 0, 0);
      for (int k = 0; k < 10; k++) begin
         c = '0;
         c.on = 1'h1;
         c.width = 2'($urandom_range(2));
         c.sinc = 1'($urandom);
         c.dinc = 1'($urandom);
         c.prio = 3'($urandom);
         len = $urandom_range(4);
         run($urandom_range(7), len, $urandom_range(len));
      end
      // Fill only toward memory with destination stepping
      c = '0;
      c.on = 1'h1;
      c.fill = 1'h1;
      c.dinc = 1'h1;
      c.width = 2'h2;
      run(5, 3, 9);
      wb(1'h1, 10'h104, 32'h18);
      c = '0;
      c.on = 1'h1;
      c.dinc = 1'h1;
      c.prio = 3'h5;
      plan(32'h100, 32'h400, 1);
      prog(4, 32'h100, 32'h400, 1, 9);
      c.prio = 3'h2;
      plan(32'h200, 32'h500, 1);
      prog(3, 32'h200, 32'h500, 1, 9);
      r0 = rd_count;
      repeat (20) @(posedge clk_i);
      chk(rd_count, r0);
      wb(1'h0, 10'h10C, 32'h0);
      chk(r & 32'hFFFF, 32'h1818);
      wb(1'h1, 10'h108, 32'h18);
      wait_off(3);
      wait_off(4);
      chk(exp_q.size(), 0);
      wb(1'h1, 10'h100, 32'hFF33);
      c = '0;
      c.on = 1'h1;
      c.trig = 1'h1;
      prog(2, 32'h600, 32'h700, 0, 9);
      // Peripheral side keeps its address fixed
      c.dinc = 1'h1;
      plan(32'h800, 32'h900, 1);
      prog(0, 32'h800, 32'h900, 1, 9);
      r0 = rd_count;
      repeat (10) @(posedge clk_i);
      chk(rd_count, r0);
      pitem(1'h0);
      pitem(1'h0);
      plan(32'hA00, 32'hB00, 0);
      prog(1, 32'hA00, 32'hB00, 0, 9);
      pitem(1'h1);
      wait_off(0);
      wait_off(1);
      chk(exp_q.size(), 0);
      wb(1'h0, 10'h10C, 32'h0);
      chk(r & 32'hFF, 32'h4);
      conclude();
   end
endmodule // tb_top
